// ---- brmsc_top.sv ----
// Buck regulator mode, protection and spread-spectrum control logic
module brmsc_top #(
	parameter int VSEL_W = brmsc_pkg::VSEL_W
) (
	input wire logic clk_in, // 20 MHz clock
	input wire logic reset_in, // Sync reset, high
	input wire logic enable_in, // Clock enable
	input wire brmsc_pkg::brmsc_otp_s otp_in, // OTP configuration
	input wire brmsc_pkg::brmsc_sense_s sense_in, // Async analog comparators
	input wire logic low_power_on_mode_in, // Mode select, async
	input wire logic [3:0] avs_address_in, // Avalon word address
	input wire logic avs_read_in, // Avalon read
	input wire logic avs_write_in, // Avalon write
	input wire logic [31:0] avs_writedata_in, // Avalon write data
	output logic [31:0] avs_readdata_out, // Avalon read data
	output logic avs_waitrequest_out, // Avalon wait
	output logic irq_out, // Level interrupt
	output logic bias_enable_out, // Internal bias supply on
	output logic buck_enable_out, // Buck on
	output logic ldo_enable_out, // Linear regulator on
	output logic pwm_mode_out, // 1 forced PWM, 0 PFM
	output logic freq_high_out, // 1 high frequency setting
	output logic peak_limit_en_out, // Peak limit active
	output logic avg_limit_en_out, // Average limit active
	output logic duty_reduce_out, // Limit hit, cut duty
	output logic bias_from_buck_switch_out, // Bias fed from buck
	output logic [VSEL_W-1:0] target_out, // Present output target
	output logic [7:0] osc_trim_out, // Signed oscillator offset
	output logic failsafe_out // Fail-safe mode
);
	// ************************************************************
	// State record
	// ************************************************************
	typedef struct packed {
		brmsc_pkg::brmsc_sense_s s1;
		brmsc_pkg::brmsc_sense_s s2;
		logic m1;
		logic m2;
		brmsc_pkg::brmsc_seq_e seq;
		logic [15:0] seq_cnt;
		logic [VSEL_W-1:0] ctrl_target;
		logic ctrl_set;
		logic [VSEL_W-1:0] target;
		logic [15:0] step_cnt;
		logic spread_en;
		logic spread_shape;
		logic [3:0] status;
		logic [3:0] mask;
		logic [15:0] tri_cnt;
		logic [7:0] tri_pos;
		logic tri_up;
		logic [1:0] rev_done;
		logic [2:0] rev_gap;
		logic [15:0] lfsr;
		logic [31:0] rdata;
		logic ack;
		logic irq;
		logic duty_reduce;
		logic bias_sw;
		logic [7:0] trim;
	} brmsc_state_s;

	brmsc_state_s r;
	brmsc_state_s next_r;

	localparam logic [15:0] HALF_CYC = 16'(brmsc_pkg::HALF_PERIOD_CYC);
	localparam logic [7:0] TRI_MAX = 8'(brmsc_pkg::DEVIATION_PCT * 2);
	localparam logic [15:0] STEP_CYC = 16'(brmsc_pkg::STEP_CYC);
	localparam logic [15:0] SEQ_CYC = 16'(brmsc_pkg::SEQ_CYC);
	localparam logic [15:0] TRI_STEP_CYC = 16'(brmsc_pkg::HALF_PERIOD_CYC
		/ (brmsc_pkg::DEVIATION_PCT * 2));
	// Random reversals stay well clear of the turning points
	localparam logic [7:0] REV_LO = (TRI_MAX >> 1) - 8'h4;
	localparam logic [7:0] REV_HI = (TRI_MAX >> 1) + 8'h4;
	localparam logic [2:0] REV_GAP = 3'h3;

	// Target in force for the present mode
	function automatic logic [VSEL_W-1:0] pick_target(
		input logic lp, input logic set, input logic [VSEL_W-1:0] ctl,
		input brmsc_pkg::brmsc_otp_s o);
		if (lp)
			pick_target = o.lp_target;
		else if (set)
			pick_target = ctl;
		else
			pick_target = o.normal_target;
	endfunction : pick_target

	logic lp;
	logic [VSEL_W-1:0] goal;
	logic ramping;
	logic hit;
	logic addr_ok;
	logic [3:0] ev;
	logic rev_first;
	logic rev_now;
	logic otp_loaded;

	// ************************************************************
	// Next-state logic
	// ************************************************************
	always_comb begin
		next_r = r;
		// Two-flop synchronisers; only stage two is read
		next_r.s1 = sense_in;
		next_r.s2 = r.s1;
		next_r.m1 = low_power_on_mode_in;
		next_r.m2 = r.m1;
		lp = r.m2;
		goal = pick_target(lp, r.ctrl_set, r.ctrl_target, otp_in);
		ramping = (r.target != goal);
		ev = 4'h0;
		// Start-up order: bias, buck, then linear regulator
		case (r.seq)
			brmsc_pkg::BRMSC_OFF: begin
				if (r.s2.supply_ok) begin
					next_r.seq = brmsc_pkg::BRMSC_BIAS;
					next_r.seq_cnt = 16'h0;
				end
			end
			brmsc_pkg::BRMSC_BIAS: begin
				next_r.seq_cnt = r.seq_cnt + 16'h1;
				if (r.seq_cnt >= SEQ_CYC - 16'h1) begin
					next_r.seq = brmsc_pkg::BRMSC_BUCK;
					next_r.seq_cnt = 16'h0;
					next_r.target = goal;
				end
			end
			brmsc_pkg::BRMSC_BUCK: begin
				next_r.seq_cnt = r.seq_cnt + 16'h1;
				if (r.seq_cnt >= SEQ_CYC - 16'h1)
					next_r.seq = otp_in.ldo_enable ? brmsc_pkg::BRMSC_LDO
						: brmsc_pkg::BRMSC_RUN;
			end
			brmsc_pkg::BRMSC_LDO: next_r.seq = brmsc_pkg::BRMSC_RUN;
			brmsc_pkg::BRMSC_RUN: begin
				if (lp && r.s2.buck_uv) begin
					next_r.seq = brmsc_pkg::BRMSC_SAFE;
					ev[brmsc_pkg::POS_FAILSAFE] = 1'b1;
				end else if (!lp && !r.s2.bias_ok) begin
					next_r.seq = brmsc_pkg::BRMSC_SAFE;
					ev[brmsc_pkg::POS_FAILSAFE] = 1'b1;
				end
			end
			brmsc_pkg::BRMSC_SAFE: next_r.seq = brmsc_pkg::BRMSC_SAFE;
			default: next_r.seq = brmsc_pkg::BRMSC_OFF;
		endcase
		// Thermal shutdown stops the buck but is not fail-safe
		if (r.s2.thermal && r.seq != brmsc_pkg::BRMSC_OFF)
			ev[brmsc_pkg::POS_THERMAL] = 1'b1;
		// Peak always, average only in PWM, negative low-side too
		hit = r.s2.peak_hit || r.s2.neg_hit
			|| (r.s2.avg_hit && (!lp || ramping));
		if (hit && buck_enable_out)
			ev[brmsc_pkg::POS_OVERCURRENT] = 1'b1;
		next_r.duty_reduce = hit && buck_enable_out;
		if (r.s2.buck_uv && buck_enable_out)
			ev[brmsc_pkg::POS_UNDERVOLTAGE] = 1'b1;
		// Step target toward goal, one code per step time
		if (ramping && r.seq == brmsc_pkg::BRMSC_RUN) begin
			next_r.step_cnt = r.step_cnt + 16'h1;
			if (r.step_cnt >= STEP_CYC - 16'h1) begin
				next_r.step_cnt = 16'h0;
				next_r.target = (r.target < goal) ? r.target + 1'b1
					: r.target - 1'b1;
			end
		end else begin
			next_r.step_cnt = 16'h0;
		end
		next_r.bias_sw = lp && !ramping && otp_in.bias_switch_allow
			&& r.target >= otp_in.bias_threshold
			&& r.seq == brmsc_pkg::BRMSC_RUN;
		// Triangle carrier with LFSR-chosen slope reversals
		next_r.lfsr = {r.lfsr[14:0], r.lfsr[15] ^ r.lfsr[13]
			^ r.lfsr[12] ^ r.lfsr[10]};
		// Two reversals per half: by chance, else forced so none is skipped
		rev_first = r.rev_done == 2'h0 && ((r.lfsr[2:0] == 3'h0
			&& r.tri_pos >= REV_LO && r.tri_pos <= REV_HI)
			|| r.tri_pos == (r.tri_up ? REV_HI - 8'h2 : REV_LO + 8'h2));
		rev_now = rev_first || (r.rev_done == 2'h1
			&& (r.lfsr[2:0] == 3'h0 || r.rev_gap >= REV_GAP));
		next_r.tri_cnt = r.tri_cnt + 16'h1;
		if (r.tri_cnt >= TRI_STEP_CYC - 16'h1) begin
			next_r.tri_cnt = 16'h0;
			if (r.tri_up)
				next_r.tri_pos = r.tri_pos + 8'h1;
			else
				next_r.tri_pos = r.tri_pos - 8'h1;
			if (r.tri_up && r.tri_pos >= TRI_MAX - 8'h1) begin
				next_r.tri_up = 1'b0;
				next_r.rev_done = 2'h0;
			end else if (!r.tri_up && r.tri_pos <= 8'h1) begin
				next_r.tri_up = 1'b1;
				next_r.rev_done = 2'h0;
			end else if (r.spread_shape && rev_now) begin
				next_r.tri_up = ~r.tri_up;
				next_r.rev_done = r.rev_done + 2'h1;
				next_r.rev_gap = 3'h0;
			end else begin
				next_r.rev_gap = r.rev_gap + 3'h1;
			end
		end
		if (r.spread_en)
			next_r.trim = r.tri_pos - (TRI_MAX >> 1);
		else
			next_r.trim = 8'h0;
		// Spread bits follow OTP until the first enabled cycle
		if (!otp_loaded) begin
			next_r.spread_en = otp_in.spread_enable_bit;
			next_r.spread_shape = otp_in.spread_shape_select_bit;
		end
		// Avalon slave: one wait state, then ack
		addr_ok = avs_address_in <= brmsc_pkg::ADDR_STATE;
		next_r.ack = (avs_read_in || avs_write_in) && !r.ack;
		if (avs_write_in && r.ack) begin
			case (avs_address_in)
				brmsc_pkg::ADDR_REGULATOR_CONTROL: begin
					next_r.ctrl_target = avs_writedata_in[VSEL_W-1:0];
					next_r.ctrl_set = 1'b1;
				end
				brmsc_pkg::ADDR_SYSTEM_CONFIG: begin
					next_r.spread_en = avs_writedata_in[brmsc_pkg::POS_SPREAD_ENABLE];
					next_r.spread_shape = avs_writedata_in[brmsc_pkg::POS_SPREAD_SHAPE];
				end
				brmsc_pkg::ADDR_STATUS:
					next_r.status = r.status & ~avs_writedata_in[3:0];
				brmsc_pkg::ADDR_MASK: next_r.mask = avs_writedata_in[3:0];
				default: ;
			endcase
		end
		next_r.status = next_r.status | ev; // Set wins over clear
		next_r.rdata = brmsc_pkg::UNMAPPED_READ;
		if (avs_read_in && !r.ack && addr_ok) begin
			case (avs_address_in)
				brmsc_pkg::ADDR_REGULATOR_CONTROL:
					next_r.rdata = 32'(r.target);
				brmsc_pkg::ADDR_SYSTEM_CONFIG:
					next_r.rdata = {30'h0, r.spread_shape, r.spread_en};
				brmsc_pkg::ADDR_STATUS: next_r.rdata = {28'h0, r.status};
				brmsc_pkg::ADDR_MASK: next_r.rdata = {28'h0, r.mask};
				brmsc_pkg::ADDR_STATE: next_r.rdata = {29'h0, r.seq};
				default: next_r.rdata = brmsc_pkg::UNMAPPED_READ;
			endcase
		end
		next_r.irq = |(next_r.status & next_r.mask);
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			r <= '0;
			r.seq <= brmsc_pkg::BRMSC_OFF;
			r.mask <= brmsc_pkg::MASK_RESET;
			r.lfsr <= brmsc_pkg::LFSR_SEED;
			r.tri_pos <= TRI_MAX >> 1;
			r.tri_up <= 1'b1;
			r.spread_en <= 1'b0;
		end else if (enable_in) begin
			r <= next_r;
		end
	end

	// OTP defaults caught on the first enabled cycle after reset
	always_ff @(posedge clk_in) begin
		if (reset_in)
			otp_loaded <= 1'b0;
		else if (enable_in)
			otp_loaded <= 1'b1;
	end

	// ************************************************************
	// Registered outputs
	// ************************************************************
	logic run_on;
	// Rails may be on anywhere between power-up and fail-safe
	assign run_on = r.seq != brmsc_pkg::BRMSC_OFF
		&& r.seq != brmsc_pkg::BRMSC_SAFE;
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			{bias_enable_out, buck_enable_out, ldo_enable_out} <= 3'h0;
			pwm_mode_out <= 1'b1;
			freq_high_out <= 1'b0;
			peak_limit_en_out <= 1'b0;
			avg_limit_en_out <= 1'b0;
			failsafe_out <= 1'b0;
		end else if (enable_in) begin
			bias_enable_out <= run_on;
			buck_enable_out <= run_on && r.seq != brmsc_pkg::BRMSC_BIAS
				&& !r.s2.thermal;
			ldo_enable_out <= otp_in.ldo_enable && (r.seq == brmsc_pkg::BRMSC_LDO
				|| r.seq == brmsc_pkg::BRMSC_RUN);
			pwm_mode_out <= !lp || ramping;
			freq_high_out <= otp_in.normal_freq_high;
			peak_limit_en_out <= run_on;
			avg_limit_en_out <= run_on && (!lp || ramping);
			failsafe_out <= r.seq == brmsc_pkg::BRMSC_SAFE;
		end
	end
	assign avs_readdata_out = r.rdata;
	assign avs_waitrequest_out = !r.ack;
	assign irq_out = r.irq;
	assign duty_reduce_out = r.duty_reduce;
	assign bias_from_buck_switch_out = r.bias_sw;
	assign target_out = r.target;
	assign osc_trim_out = r.trim;

	// ************************************************************
	// Assertions
	// ************************************************************
	// Fail-safe must leave every rail off
	property p_failsafe_off;
		@(posedge clk_in) disable iff (reset_in)
		failsafe_out |-> !bias_enable_out && !buck_enable_out
			&& !ldo_enable_out;
	endproperty
	a_failsafe_off: assert property (p_failsafe_off)
		else $error("rail still on in fail-safe");

	// Normal mode always switches forced PWM
	property p_pwm_normal;
		@(posedge clk_in) disable iff (reset_in)
		enable_in && !r.m2 |=> pwm_mode_out;
	endproperty
	a_pwm_normal: assert property (p_pwm_normal)
		else $error("PFM used in normal mode");

	// Average limit only exists while in PWM
	property p_avg_in_pwm;
		@(posedge clk_in) disable iff (reset_in)
		avg_limit_en_out |-> pwm_mode_out;
	endproperty
	a_avg_in_pwm: assert property (p_avg_in_pwm)
		else $error("average limit armed in PFM");

	// A limit hit while the buck is on always lands in the sticky flag
	property p_oc_flag;
		@(posedge clk_in) disable iff (reset_in)
		enable_in && hit && buck_enable_out
		|=> r.status[brmsc_pkg::POS_OVERCURRENT];
	endproperty
	a_oc_flag: assert property (p_oc_flag)
		else $error("overcurrent flag not set");

	// Flag holds until software writes a one to it
	property p_flag_sticky;
		@(posedge clk_in) disable iff (reset_in)
		enable_in && r.status[brmsc_pkg::POS_OVERCURRENT] && !(avs_write_in
			&& r.ack && avs_address_in == brmsc_pkg::ADDR_STATUS)
		|=> r.status[brmsc_pkg::POS_OVERCURRENT];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky)
		else $error("overcurrent flag lost");

	// Over-temperature turns the buck off next cycle
	property p_thermal_off;
		@(posedge clk_in) disable iff (reset_in)
		enable_in && r.s2.thermal |=> !buck_enable_out;
	endproperty
	a_thermal_off: assert property (p_thermal_off)
		else $error("buck on during thermal shutdown");

	// Spread off means no oscillator offset at all
	property p_spread_off;
		@(posedge clk_in) disable iff (reset_in)
		enable_in && !r.spread_en |=> osc_trim_out == 8'h0;
	endproperty
	a_spread_off: assert property (p_spread_off)
		else $error("offset present with spread off");

	// Carrier never leaves the deviation band
	property p_trim_range;
		@(posedge clk_in) disable iff (reset_in)
		r.tri_pos <= TRI_MAX;
	endproperty
	a_trim_range: assert property (p_trim_range)
		else $error("carrier outside deviation band");

	// Acknowledge lasts a single cycle
	property p_ack_pulse;
		@(posedge clk_in) disable iff (reset_in)
		enable_in && !avs_waitrequest_out |=> avs_waitrequest_out;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("waitrequest low two cycles");

	// Main scenarios worth seeing
	c_failsafe: cover property (@(posedge clk_in) $rose(failsafe_out));
	c_lp_pfm: cover property (@(posedge clk_in) r.m2 && !pwm_mode_out);
	c_two_rev: cover property (@(posedge clk_in) r.rev_done == 2'h2);
	c_dvs: cover property (@(posedge clk_in) r.ctrl_set && ramping);
endmodule : brmsc_top

// ---- brmsc_pkg.sv ----
// Package of constants and types for the buck mode and spread control block
//
// Overview of operation
// - Above supply threshold start bias, then buck, then linear regulator if OTP enables it.
// - Buck switches forced PWM in Normal mode, PFM in low-power-on mode.
// - Separate Normal and low-power-on targets; ramps between them run in PWM.
// - Switching frequency and output target both come from OTP configuration.
// - PWM enforces peak and average limits; PFM only peak; thresholds from OTP.
// - Large negative low-side current counts as an overcurrent condition.
// - Any current limit sets overcurrent flag; regulator stays on, duty reduced.
// - Output below undervoltage threshold sets the buck undervoltage flag.
// - Thermal shutdown disables the buck and sets the thermal-shutdown flag.
// - Software writes regulator control register; target applied by voltage scaling.
// - Buck undervoltage in low-power-on mode sends device to fail-safe, all off.
// - Supply below bias threshold in Normal mode sends device to fail-safe.
// - Low-power-on, target at least threshold, OTP enabled: close bias-from-buck switch.
// - Spread on: oscillator modulated by low-frequency carrier, plus or minus ten percent.
// - After reset spread-enable and shape bits take their OTP default values.
// - Spread on, shape zero: pure triangular carrier modulation.
// - Spread on, shape one: triangular with two random slope reversals per half.
package brmsc_pkg;
	// ************************************************************
	// Register map (word offsets on the Avalon bus)
	// ************************************************************
	localparam logic [3:0] ADDR_REGULATOR_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_SYSTEM_CONFIG = 4'h1;
	localparam logic [3:0] ADDR_STATUS = 4'h2;
	localparam logic [3:0] ADDR_MASK = 4'h3;
	localparam logic [3:0] ADDR_STATE = 4'h4;
	localparam int VSEL_W = 8;
	localparam int POS_SPREAD_ENABLE = 0;
	localparam int POS_SPREAD_SHAPE = 1;
	localparam int POS_OVERCURRENT = 0;
	localparam int POS_UNDERVOLTAGE = 1;
	localparam int POS_THERMAL = 2;
	localparam int POS_FAILSAFE = 3;
	localparam logic [3:0] MASK_RESET = 4'h0;
	localparam logic [31:0] UNMAPPED_READ = 32'h0;
	// ************************************************************
	// Timing and modulation
	// ************************************************************
	localparam int CLK_HZ = 20000000;
	localparam int CARRIER_HZ = 19000;
	localparam int DEVIATION_PCT = 10;
	localparam int HALF_PERIOD_CYC = CLK_HZ / (2 * CARRIER_HZ);
	localparam int STEP_SETTLE_US = 1;
	localparam int STEP_CYC = (STEP_SETTLE_US * CLK_HZ + 999999) / 1000000;
	localparam int SEQ_SETTLE_US = 10;
	localparam int SEQ_CYC = (SEQ_SETTLE_US * CLK_HZ + 999999) / 1000000;
	localparam logic [15:0] LFSR_SEED = 16'hace1;
	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [2:0] {
		BRMSC_OFF, BRMSC_BIAS, BRMSC_BUCK, BRMSC_LDO, BRMSC_RUN, BRMSC_SAFE
	} brmsc_seq_e;
	typedef struct packed {
		logic normal_freq_high;
		logic [VSEL_W-1:0] normal_target;
		logic [VSEL_W-1:0] lp_target;
		logic [VSEL_W-1:0] bias_threshold;
		logic bias_switch_allow;
		logic ldo_enable;
		logic spread_enable_bit;
		logic spread_shape_select_bit;
	} brmsc_otp_s;
	typedef struct packed {
		logic supply_ok;
		logic bias_ok;
		logic buck_uv;
		logic peak_hit;
		logic avg_hit;
		logic neg_hit;
		logic thermal;
	} brmsc_sense_s;
endpackage : brmsc_pkg

// ---- brmsc_sense_model.sv ----
// Comparator model of the analog side of the buck converter
module brmsc_sense_model (
	input wire logic clk_in, // 20 MHz clock
	input wire logic fault_uv_in, // Force supply below bias level
	input wire logic fault_oc_in, // Force peak current hit
	input wire logic fault_neg_in, // Force negative current hit
	input wire logic fault_hot_in, // Force over-temperature
	input wire logic duty_reduce_in, // Limiter cutting duty
	output brmsc_pkg::brmsc_sense_s sense_out // Comparator outputs
);
	// ************************************************************
	// Comparators
	// ************************************************************
	// Droop follows the limiter, so undervoltage appears only after a limit
	always_ff @(posedge clk_in) begin
		sense_out.supply_ok <= 1'b1;
		sense_out.bias_ok <= !fault_uv_in;
		sense_out.buck_uv <= duty_reduce_in;
		sense_out.peak_hit <= fault_oc_in;
		sense_out.avg_hit <= 1'b0;
		sense_out.neg_hit <= fault_neg_in;
		sense_out.thermal <= fault_hot_in;
	end
endmodule : brmsc_sense_model

// ---- brmsc_tb_top.sv ----
// Self-checking bench for the buck mode and spread control block
module brmsc_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic lp = 1'b0;
	logic f_uv = 1'b0;
	logic f_oc = 1'b0;
	logic f_neg = 1'b0;
	logic f_hot = 1'b0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [31:0] got;
	logic wrq, irq, bias, buck, ldo, pwm, fhi, pk, avg, duty, bsw, fs;
	logic [7:0] tgt;
	logic [7:0] trim;
	brmsc_pkg::brmsc_sense_s sense;
	brmsc_pkg::brmsc_otp_s otp = '{1'b1, 8'h50, 8'h30, 8'h30, 1'b1, 1'b1,
		1'b1, 1'b0};
	int error_cnt = 0;
	int total_checks = 0;
	int cycles = 0;
	int nz, rv;
	localparam int HALF = brmsc_pkg::HALF_PERIOD_CYC;
	// ************************************************************
	// Clock, timeout and instances
	// ************************************************************
	always #25 clk_in = ~clk_in;
	// Hang guard, well above the sum of all scenario waits
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 60000) begin
			error_cnt++;
			conclude();
		end
	end
	brmsc_top brmsc_top_inst (.clk_in(clk_in), .reset_in(reset_in),
		.enable_in(1'b1), .otp_in(otp), .sense_in(sense),
		.low_power_on_mode_in(lp), .avs_address_in(addr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
		.avs_readdata_out(rdata), .avs_waitrequest_out(wrq),
		.irq_out(irq), .bias_enable_out(bias), .buck_enable_out(buck),
		.ldo_enable_out(ldo), .pwm_mode_out(pwm), .freq_high_out(fhi),
		.peak_limit_en_out(pk), .avg_limit_en_out(avg),
		.duty_reduce_out(duty), .bias_from_buck_switch_out(bsw),
		.target_out(tgt), .osc_trim_out(trim), .failsafe_out(fs));
	brmsc_sense_model brmsc_sense_model_inst (.clk_in(clk_in),
		.fault_uv_in(f_uv), .fault_oc_in(f_oc), .fault_neg_in(f_neg),
		.fault_hot_in(f_hot), .duty_reduce_in(duty), .sense_out(sense));
	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
	endtask : cyc
	// Avalon cycle: held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge clk_in);
			n++;
		end while (wrq !== 1'b0 && n < 50);
		got = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		if (n >= 50) chk(32'h1, 32'h0);
	endtask : bus
	// Reset, then note the cycle each rail first comes up
	task automatic start();
		int tb, tk, tl;
		tb = 0;
		tk = 0;
		tl = 0;
		@(posedge clk_in);
		reset_in <= 1'b1;
		cyc(2);
		reset_in <= 1'b0;
		for (int i = 1; i < 8 * brmsc_pkg::SEQ_CYC; i++) begin
			@(posedge clk_in);
			if (tb == 0 && bias === 1'b1) tb = i;
			if (tk == 0 && buck === 1'b1) tk = i;
			if (tl == 0 && ldo === 1'b1) tl = i;
		end
		chk(32'(tb > 0 && tb < tk), 32'h1);
		chk(32'(tk < tl), 32'h1);
	endtask : start
	// Window of win cycles (two or four carrier halves): nonzero offsets and slope reversals
	task automatic spread(input logic [31:0] cfg, input int win);
		logic [7:0] last;
		int dir, d;
		bus(1'b1, brmsc_pkg::ADDR_SYSTEM_CONFIG, cfg);
		cyc(HALF);
		nz = 0;
		rv = 0;
		dir = 0;
		last = trim;
		for (int i = 0; i < win; i++) begin
			@(posedge clk_in);
			if (trim !== 8'h0) nz++;
			if (trim !== last) begin
				d = ($signed(trim) > $signed(last)) ? 1 : -1;
				if (dir != 0 && d != dir) rv++;
				dir = d;
			end
			last = trim;
		end
	endtask : spread
	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_reset();
		bus(1'b0, brmsc_pkg::ADDR_SYSTEM_CONFIG, 32'h0);
		chk(got & 32'h3, 32'h1);
		bus(1'b0, brmsc_pkg::ADDR_MASK, 32'h0);
		chk(got, 32'(brmsc_pkg::MASK_RESET));
		bus(1'b0, 4'hf, 32'h0);
		chk(got, brmsc_pkg::UNMAPPED_READ);
		chk({fhi, pwm, pk, avg}, 32'hf);
		chk(tgt, 32'h50);
	endtask : t_reset
	// Limit hits set sticky flags, mask and write-one-to-clear
	task automatic t_limit();
		f_oc <= 1'b1;
		cyc(6);
		chk({buck, duty}, 32'h3);
		f_oc <= 1'b0;
		cyc(6);
		bus(1'b0, brmsc_pkg::ADDR_STATUS, 32'h0);
		chk(got & 32'h3, 32'h3);
		chk(irq, 32'h0);
		bus(1'b1, brmsc_pkg::ADDR_MASK, 32'hf);
		cyc(2);
		chk(irq, 32'h1);
		bus(1'b1, brmsc_pkg::ADDR_STATUS, 32'h3);
		cyc(2);
		chk(irq, 32'h0);
		bus(1'b1, brmsc_pkg::ADDR_MASK, 32'h0);
		f_neg <= 1'b1;
		cyc(4);
		f_neg <= 1'b0;
		cyc(6);
		bus(1'b0, brmsc_pkg::ADDR_STATUS, 32'h0);
		chk(got & 32'h1, 32'h1);
		bus(1'b1, brmsc_pkg::ADDR_STATUS, 32'hf);
	endtask : t_limit
	task automatic t_dvs();
		bus(1'b1, brmsc_pkg::ADDR_REGULATOR_CONTROL, 32'h44);
		for (int i = 0; i < 2000 && tgt !== 8'h44; i++) @(posedge clk_in);
		chk(tgt, 32'h44);
	endtask : t_dvs
	// Ramp to the low-power target in PWM, then PFM and fail-safe
	task automatic t_lp();
		int bad;
		bad = 0;
		lp <= 1'b1;
		for (int i = 0; i < 4000 && tgt !== 8'h30; i++) begin
			@(posedge clk_in);
			if (tgt !== 8'h30 && pwm !== 1'b1) bad++;
		end
		cyc(4);
		chk(32'(bad), 32'h0);
		chk({tgt, pwm, pk, avg, bsw}, {20'h0, 8'h30, 4'h5});
		f_oc <= 1'b1;
		cyc(12);
		f_oc <= 1'b0;
		chk({fs, bias, buck, ldo}, 32'h8);
		lp <= 1'b0;
	endtask : t_lp
	task automatic t_uv();
		f_uv <= 1'b1;
		cyc(6);
		chk({fs, bias, buck, ldo}, 32'h8);
		f_uv <= 1'b0;
	endtask : t_uv
	task automatic t_hot();
		f_hot <= 1'b1;
		cyc(6);
		chk(buck, 32'h0);
		bus(1'b0, brmsc_pkg::ADDR_STATUS, 32'h0);
		chk(got & 32'h4, 32'h4);
		f_hot <= 1'b0;
	endtask : t_hot
	task automatic t_spread();
		spread(32'h0, 2 * HALF);
		chk(32'(nz), 32'h0);
		spread(32'h2, 2 * HALF);
		chk(32'(nz), 32'h0);
		spread(32'h1, 2 * HALF);
		chk(32'(nz > 0 && rv <= 3), 32'h1);
		spread(32'h3, 4 * HALF);
		chk(32'(nz > 0 && rv >= 6), 32'h1);
	endtask : t_spread
	task automatic conclude();
		$display("checks=%0d errors=%0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : conclude
	// Main sequence; fail-safe cases each need a fresh power-up
	initial begin
		start();
		t_reset();
		t_limit();
		t_dvs();
		t_spread();
		t_lp();
		start();
		t_uv();
		start();
		t_hot();
		conclude();
	end
endmodule : brmsc_tb_top
